// File: verilog/xma_core.sv
// Sequencer-facing core: fetches the far operand, executes, writes back.
`default_nettype none
module xma_core
    import xma_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Request from the instruction sequencer.
    input wire logic start_i,
    input wire xma_req_t req_i,
    // Direct loads of the working register and flags by other instructions.
    input wire logic wreg_load_i,
    input wire logic [DATA_W-1:0] wreg_load_data_i,
    input wire logic flags_load_i,
    input wire xma_flags_t flags_load_data_i,
    // Data memory port.
    input wire logic mem_rvalid_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    // State seen by the sequencer.
    output logic busy_o,
    output logic done_o,
    output logic [DATA_W-1:0] working_register_o,
    output xma_flags_t flags_o
);
    typedef enum logic [1:0] {st_idle, st_fetch, st_exec} xma_state_t;

    xma_state_t state;
    xma_req_t req_q;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] alu_result;
    xma_flags_t alu_flags;
    logic alu_to_mem;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic and logic.

    xma_alu u_alu (
        .op_i(req_q.op),
        .bit_sel_i(req_q.bit_sel),
        .wreg_i(working_register_o),
        .mem_i(mem_q),
        .flags_i(flags_o),
        .result_o(alu_result),
        .flags_o(alu_flags),
        .to_mem_o(alu_to_mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencing.

    // Control state: a request is taken only while idle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= st_idle;
        end else begin
            unique case (state)
                st_idle: begin
                    if (start_i) begin
                        state <= st_fetch;
                    end
                end
                st_fetch: begin
                    if (mem_rvalid_i) begin
                        state <= st_exec;
                    end
                end
                st_exec: begin
                    state <= st_idle;
                end
                // The fourth code is unused; fall back to idle if it ever appears.
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Request capture and operand latch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_q <= '0;
            mem_q <= WREG_RST;
        end else begin
            if (state == st_idle && start_i) begin
                req_q <= req_i;
            end
            if (state == st_fetch && mem_rvalid_i) begin
                mem_q <= mem_rdata_i;
            end
        end
    end

    // Memory read: the full sector and offset go out, no current sector used.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_rd_o <= 1'b0;
            mem_addr_o <= ADDR_RST;
        end else begin
            mem_rd_o <= (state == st_idle) && start_i;
            if (state == st_idle && start_i) begin
                mem_addr_o <= {req_i.sector, req_i.offset};
            end
        end
    end

    // Write back to memory for the memory-destination operations.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_wr_o <= 1'b0;
            mem_wdata_o <= WREG_RST;
        end else begin
            mem_wr_o <= (state == st_exec) && alu_to_mem;
            if (state == st_exec && alu_to_mem) begin
                mem_wdata_o <= alu_result;
            end
        end
    end

    // Working register and flags; external loads are ignored while busy.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            working_register_o <= WREG_RST;
            flags_o <= FLAGS_RST;
        end else if (state == st_exec) begin
            if (!alu_to_mem) begin
                working_register_o <= alu_result;
            end
            flags_o <= alu_flags;
        end else if (state == st_idle) begin
            if (wreg_load_i) begin
                working_register_o <= wreg_load_data_i;
            end
            if (flags_load_i) begin
                flags_o <= flags_load_data_i;
            end
        end
    end

    // Status toward the sequencer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            busy_o <= (state == st_idle) ? start_i : (state != st_exec);
            done_o <= (state == st_exec);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A request taken while idle.
    sequence s_taken;
        state == st_idle && start_i;
    endsequence

    // The read that follows it, at the full address.
    sequence s_read(logic [ADDR_W-1:0] a);
        mem_rd_o && mem_addr_o == a;
    endsequence

    chk_addr_full_sector: assert property (
        s_taken |=> s_read($past({req_i.sector, req_i.offset})))
        else $error("far read address does not match requested sector and offset");

    chk_adc_acc_sum: assert property (
        done_o && req_q.op == op_far_add_with_carry |->
        working_register_o == 8'($past(working_register_o) + mem_q +
                                 {7'h00, $past(flags_o.carry_flag)}) && !mem_wr_o)
        else $error("add with carry result wrong in working register");

    chk_adcm_mem_sum: assert property (
        done_o && req_q.op == op_far_add_with_carry_to_mem |->
        mem_wr_o && $stable(working_register_o) &&
        mem_wdata_o == 8'(working_register_o + mem_q + {7'h00, $past(flags_o.carry_flag)}))
        else $error("add with carry to memory result wrong");

    chk_add_acc_sum: assert property (
        done_o && req_q.op == op_far_add |->
        working_register_o == 8'($past(working_register_o) + mem_q) &&
        flags_o.carry_flag == ({1'b0, $past(working_register_o)} + {1'b0, mem_q} > 9'h0FF))
        else $error("add result or carry wrong");

    chk_addm_mem_sum: assert property (
        done_o && req_q.op == op_far_add_to_mem |->
        mem_wr_o && mem_wdata_o == 8'(working_register_o + mem_q) &&
        flags_o.zero_flag == (mem_wdata_o == 8'h00))
        else $error("add to memory result or zero flag wrong");

    chk_and_acc_zero: assert property (
        done_o && req_q.op == op_far_bitwise_and |->
        working_register_o == ($past(working_register_o) & mem_q) &&
        flags_o.zero_flag == (working_register_o == 8'h00))
        else $error("AND result or zero flag wrong");

    chk_andm_mem_value: assert property (
        done_o && req_q.op == op_far_bitwise_and_to_mem |->
        mem_wr_o && mem_wdata_o == (working_register_o & mem_q))
        else $error("AND to memory result wrong");

    chk_clear_mem_zero: assert property (
        done_o && req_q.op == op_far_clear |->
        mem_wr_o && mem_wdata_o == CLEAR_VALUE && flags_o == $past(flags_o))
        else $error("clear did not write zero or changed flags");

    chk_bitclr_mem_bit: assert property (
        done_o && req_q.op == op_far_bit_clear |->
        mem_wr_o && mem_wdata_o == (mem_q & ~(8'h01 << req_q.bit_sel)) &&
        flags_o == $past(flags_o))
        else $error("bit clear wrote wrong value or changed flags");

    chk_logic_flags_kept: assert property (
        done_o && (req_q.op == op_far_bitwise_and || req_q.op == op_far_bitwise_and_to_mem) |->
        flags_o.carry_flag == $past(flags_o.carry_flag) &&
        flags_o.half_carry_flag == $past(flags_o.half_carry_flag) &&
        flags_o.signed_wrap_flag == $past(flags_o.signed_wrap_flag) &&
        flags_o.signed_carry_flag == $past(flags_o.signed_carry_flag))
        else $error("AND changed a flag other than zero");
endmodule
`default_nettype wire

// File: verilog/xma_pkg.sv
// Package of constants and types for the extended memory ALU operations.
`default_nettype none
package xma_pkg;
    localparam int DATA_W = 8;
    localparam int SECTOR_W = 3;
    localparam int OFFSET_W = 8;
    localparam int ADDR_W = SECTOR_W + OFFSET_W;
    localparam int BIT_W = 3;
    localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
    localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

    // Operations carried out by the block.
    typedef enum logic [2:0] {
        op_far_add_with_carry,
        op_far_add_with_carry_to_mem,
        op_far_add,
        op_far_add_to_mem,
        op_far_bitwise_and,
        op_far_bitwise_and_to_mem,
        op_far_clear,
        op_far_bit_clear
    } xma_op_t;

    // Status flags held by the block.
    typedef struct packed {
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic signed_carry_flag;
    } xma_flags_t;

    localparam xma_flags_t FLAGS_RST = '0;

    // One request from the instruction sequencer.
    typedef struct packed {
        xma_op_t op;
        logic [SECTOR_W-1:0] sector;
        logic [OFFSET_W-1:0] offset;
        logic [BIT_W-1:0] bit_sel;
    } xma_req_t;
endpackage
`default_nettype wire

// File: verilog/xma_alu.sv
// Combinational result and flag computation for the extended operations.
`default_nettype none
module xma_alu
    import xma_pkg::*;
(
    // Operation and operands.
    input wire xma_op_t op_i,
    input wire logic [BIT_W-1:0] bit_sel_i,
    input wire logic [DATA_W-1:0] wreg_i,
    input wire logic [DATA_W-1:0] mem_i,
    input wire xma_flags_t flags_i,
    // Result.
    output logic [DATA_W-1:0] result_o,
    output xma_flags_t flags_o,
    output logic to_mem_o
);
    logic cin;
    logic [DATA_W:0] sum;
    logic [4:0] half;
    logic carry_in7;

    // Shared adder; the carry input is used only by the with-carry forms.
    always_comb begin
        cin = (op_i == op_far_add_with_carry) || (op_i == op_far_add_with_carry_to_mem) ?
              flags_i.carry_flag : 1'b0;
        sum = {1'b0, wreg_i} + {1'b0, mem_i} + {8'h00, cin};
        half = {1'b0, wreg_i[3:0]} + {1'b0, mem_i[3:0]} + {4'h0, cin};
        carry_in7 = wreg_i[7] ^ mem_i[7] ^ sum[7];
    end

    // Result, destination and flag selection per operation.
    always_comb begin
        result_o = wreg_i;
        flags_o = flags_i;
        to_mem_o = 1'b0;
        unique case (op_i)
            op_far_add_with_carry, op_far_add_with_carry_to_mem,
            op_far_add, op_far_add_to_mem: begin
                result_o = sum[DATA_W-1:0];
                flags_o.carry_flag = sum[DATA_W];
                flags_o.half_carry_flag = half[4];
                flags_o.signed_wrap_flag = carry_in7 ^ sum[DATA_W];
                flags_o.signed_carry_flag = wreg_i[7] ^ mem_i[7] ^ sum[DATA_W];
                flags_o.zero_flag = (sum[DATA_W-1:0] == 8'h00);
                to_mem_o = (op_i == op_far_add_with_carry_to_mem) ||
                           (op_i == op_far_add_to_mem);
            end
            op_far_bitwise_and, op_far_bitwise_and_to_mem: begin
                result_o = wreg_i & mem_i;
                flags_o.zero_flag = ((wreg_i & mem_i) == 8'h00);
                to_mem_o = (op_i == op_far_bitwise_and_to_mem);
            end
            op_far_clear: begin
                result_o = CLEAR_VALUE;
                to_mem_o = 1'b1;
            end
            op_far_bit_clear: begin
                result_o = mem_i & ~(8'h01 << bit_sel_i);
                to_mem_o = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: tb/xma_mem_model.sv
// Data memory model that answers the core's reads after a chosen latency.
`default_nettype none
module xma_mem_model
    import xma_pkg::*;
(
    // Clock, reset and latency choice.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] lat_i,
    // Memory port of the core.
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic [DATA_W-1:0] mem_wdata_i,
    output logic mem_rvalid_o,
    output logic [DATA_W-1:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [DATA_W-1:0] mem [0:2**ADDR_W-1];
    logic [1:0] cnt;
    logic pend;
    logic [DATA_W-1:0] last;

    ////////////////////////////////////////////////////////////////////
    // Writes land at the full address; reads are answered after lat_i.
    always @(posedge clk_i) begin
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        if (rst_i) begin
            pend <= 1'b0;
        end else if (mem_rd_i && lat_i != 2'h0) begin
            pend <= 1'b1;
            cnt <= lat_i - 2'h1;
        end else if (pend && cnt == 2'h0) begin
            pend <= 1'b0;
        end else if (pend) begin
            cnt <= cnt - 2'h1;
        end
        if (mem_rvalid_o) begin
            last <= mem_rdata_o;
        end
    end

    // Outside a valid cycle the data lines show garbage, not stale data.
    assign mem_rvalid_o = (mem_rd_i && lat_i == 2'h0) || (pend && cnt == 2'h0);
    assign mem_rdata_o = mem_rvalid_o ? mem[mem_addr_i] : ~last;
endmodule
`default_nettype wire

// File: tb/extended_memory_alu_ops_tb.sv
// Self-checking testbench for the extended memory operation core.
`default_nettype none
module extended_memory_alu_ops_tb
    import xma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // One case: op, bit, working register, byte, result, flags before, after.
    typedef struct packed {
        xma_op_t op;
        logic [BIT_W-1:0] sel;
        logic [DATA_W-1:0] wreg, m, res;
        xma_flags_t pre, post;
    } xma_row_t;

    localparam xma_row_t ROWS [10] = '{
        '{op_far_add_with_carry, 3'h0, 8'h7F, 8'h00, 8'h80, 5'h0B, 5'h14},
        '{op_far_add_with_carry_to_mem, 3'h0, 8'hFF, 8'h00, 8'h00, 5'h02, 5'h0E},
        '{op_far_add, 3'h0, 8'h08, 8'h08, 8'h10, 5'h0B, 5'h04},
        '{op_far_add_to_mem, 3'h0, 8'h80, 8'h80, 8'h00, 5'h07, 5'h1B},
        '{op_far_bitwise_and, 3'h0, 8'hF0, 8'h0F, 8'h00, 5'h17, 5'h1F},
        '{op_far_bitwise_and_to_mem, 3'h0, 8'h3C, 8'h0F, 8'h0C, 5'h0A, 5'h02},
        '{op_far_clear, 3'h0, 8'h55, 8'hA7, 8'h00, 5'h15, 5'h15},
        '{op_far_bit_clear, 3'h7, 8'h00, 8'hFF, 8'h7F, 5'h0A, 5'h0A},
        '{op_far_bit_clear, 3'h0, 8'h00, 8'h01, 8'h00, 5'h1F, 5'h1F},
        '{op_far_add_with_carry, 3'h0, 8'h0F, 8'h01, 8'h10, 5'h1D, 5'h04}
    };

    logic clk_i, rst_i, start_i, wreg_load_i, flags_load_i, mem_rvalid_i;
    logic mem_rd_o, mem_wr_o, busy_o, done_o;
    logic [1:0] lat;
    xma_req_t req_i;
    logic [DATA_W-1:0] wreg_load_data_i, mem_rdata_i, mem_wdata_o, working_register_o;
    xma_flags_t flags_load_data_i, flags_o;
    logic [ADDR_W-1:0] mem_addr_o;
    int error_cnt = 0;
    int n_checks = 0;

    xma_core dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .req_i(req_i),
        .wreg_load_i(wreg_load_i), .wreg_load_data_i(wreg_load_data_i),
        .flags_load_i(flags_load_i), .flags_load_data_i(flags_load_data_i),
        .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .busy_o(busy_o), .done_o(done_o), .working_register_o(working_register_o),
        .flags_o(flags_o));

    xma_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .mem_rd_i(mem_rd_o),
        .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));

    ////////////////////////////////////////////////////////////////////
    // Counts a comparison and reports a mismatch.
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Loads the operands, runs one operation and checks where the result went.
    task automatic run(input xma_row_t r, input int i, input logic poke);
        logic [ADDR_W-1:0] a;
        logic tm;
        int k;
        a = {i[2:0], 8'h3C ^ 8'(i)};
        tm = r.op[0] || r.op == op_far_clear;
        mdl.mem[a] = r.m;
        @(posedge clk_i);
        wreg_load_i <= 1'b1;
        wreg_load_data_i <= r.wreg;
        flags_load_i <= 1'b1;
        flags_load_data_i <= r.pre;
        lat <= 2'(i % 3);
        @(posedge clk_i);
        wreg_load_i <= 1'b0;
        flags_load_i <= 1'b0;
        start_i <= 1'b1;
        req_i <= '{r.op, a[10:8], a[7:0], r.sel};
        @(posedge clk_i);
        start_i <= 1'b0;
        wreg_load_i <= poke;
        wreg_load_data_i <= ~r.wreg;
        // The read strobe stands only in the cycle after the request is taken.
        @(negedge clk_i);
        cmp(16'({busy_o, mem_rd_o}), 16'h0003, "fetch strobes");
        cmp(16'(mem_addr_o), 16'(a), "address");
        @(posedge clk_i);
        wreg_load_i <= 1'b0;
        for (k = 0; k < 20 && done_o !== 1'b1; k++) begin
            @(negedge clk_i);
        end
        if (done_o !== 1'b1) begin
            cmp(16'h0, 16'h1, "no completion");
            report_and_stop();
        end else begin
            cmp(16'(flags_o), 16'(r.post), "flags");
            cmp(16'(working_register_o), 16'(tm ? r.wreg : r.res), "work reg");
            cmp(16'({busy_o, mem_wr_o}), 16'(tm), "write strobe");
            cmp(16'(mem_addr_o), 16'(a), "write address");
            @(negedge clk_i);
            cmp(16'(mdl.mem[a]), 16'(tm ? r.res : r.m), "byte");
        end
    endtask

    // Everything the sequencer sees is back at its reset value.
    task automatic rst_chk();
        cmp({busy_o, done_o, mem_wr_o, flags_o, working_register_o},
            {3'h0, FLAGS_RST, WREG_RST}, "reset state");
    endtask

    ////////////////////////////////////////////////////////////////////
    // Free-running clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Main sequence: table rows, a refused load, then a reset mid-operation.
    initial begin
        rst_i = 1'b1;
        start_i = 1'b0;
        req_i = '0;
        wreg_load_i = 1'b0;
        wreg_load_data_i = '0;
        flags_load_i = 1'b0;
        flags_load_data_i = '0;
        lat = 2'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        rst_chk();
        for (int i = 0; i < 10; i++) begin
            run(ROWS[i], i, 1'b0);
        end
        run(ROWS[2], 4, 1'b1);
        @(posedge clk_i);
        start_i <= 1'b1;
        req_i <= '{op_far_add_to_mem, 3'h5, 8'h10, 3'h0};
        @(posedge clk_i);
        start_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        rst_chk();
        run(ROWS[3], 7, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
